// File: hw/wt_pkg.sv
package wt_pkg;

    // Register addresses on the internal bus
    localparam logic [15:0] TCS_ADDR = 16'hff42;
    localparam logic [15:0] WMC_ADDR = 16'hff4a;

    // Reset values and writable bit masks
    localparam logic [7:0] TCS_RESET = 8'h00;
    localparam logic [7:0] WMC_RESET = 8'h00;
    localparam logic [7:0] TCS_RW_MASK = 8'hf7;
    localparam logic [7:0] WMC_RW_MASK = 8'h7f;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // Clock select field positions
    localparam int TCS_WDOG_LSB = 0;
    localparam int TCS_SRC_BIT = 4;
    localparam int TCS_BUZ_LSB = 5;
    localparam int TCS_BUZ_EN_BIT = 7;

    // Watch mode control field positions
    localparam int WMC_FAST_BIT = 0;
    localparam int WMC_PRE_RUN_BIT = 1;
    localparam int WMC_CNT_RUN_BIT = 2;
    localparam int WMC_PERIOD_BIT = 3;
    localparam int WMC_IVL_LSB = 4;

    // Divider and counter geometry
    localparam int MAIN_DIV_W = 7;
    localparam int PRE_W = 9;
    localparam int CNT_W = 5;
    localparam int IVL_MIN_EXP = 4;
    localparam logic [2:0] IVL_MAX_CODE = 3'h5;
    localparam int FAST_EXP = 5;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic bit_wr;
        logic [2:0] bit_idx;
        logic rd;
    } wt_bus_req_t;

    typedef struct packed {
        logic [2:0] wdog_clock_sel;
        logic buzzer_enable_bit;
        logic [1:0] buzzer_freq_sel;
    } wt_sel_t;

endpackage

// File: hw/wt_sync_rise.sv
`timescale 1ns/1ns
module wt_sync_rise (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic pin_in,
    output logic rise
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // Two flops before any logic reads the pin
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign rise = sync_q & ~last_q;
endmodule

// File: hw/wt_watch_timer.sv
`timescale 1ns/1ns
module wt_watch_timer (
    input wire logic ref_clk,
    input wire logic rst,
    input wt_pkg::wt_bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    input wire logic osc_tick,
    input wire logic main_clock_undivided,
    input wire logic sub_clk_pin,
    input wire logic watch_irq_flag_clr,
    input wire logic watch_irq_mask,
    output logic watch_irq_flag,
    output logic watch_irq,
    output logic interval_irq,
    output logic standby_release,
    output wt_pkg::wt_sel_t sel_out
);
    logic [7:0] tcs_q;
    logic [7:0] wmc_q;
    logic [7:0] rdata_q;
    logic half_q;
    logic [wt_pkg::MAIN_DIV_W-1:0] div_q;
    logic [wt_pkg::PRE_W-1:0] pre_q;
    logic [wt_pkg::CNT_W-1:0] cnt_q;
    logic flag_q;
    logic watch_irq_q;
    logic interval_irq_q;
    logic sub_rise;
    logic fxx_tick;
    logic fw_tick;
    logic pre_run;
    logic cnt_run;
    logic [2:0] ivl_code;
    logic watch_hit;
    logic ivl_hit;
    logic cnt_step;

    function automatic logic addr_is(input logic [15:0] a, input logic [15:0] r);
        addr_is = (a == r);
    endfunction

    // True when the low n prescaler bits are all ones
    function automatic logic low_ones(input logic [wt_pkg::PRE_W-1:0] p, input int n);
        logic r;
        r = 1'b1;
        for (int i = 0; i < wt_pkg::PRE_W; i++) begin
            if (i < n) begin
                r = r & p[i];
            end
        end
        low_ones = r;
    endfunction

    wt_sync_rise u_sub_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin_in(sub_clk_pin),
        .rise(sub_rise)
    );

    // Clock select register, whole-byte writes only
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tcs_q <= wt_pkg::TCS_RESET;
        end else if (bus_req.wr && addr_is(bus_req.addr, wt_pkg::TCS_ADDR)) begin
            tcs_q <= bus_req.wdata & wt_pkg::TCS_RW_MASK;
        end
    end

    // Mode control register, byte or single-bit writes
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wmc_q <= wt_pkg::WMC_RESET;
        end else if (bus_req.wr && addr_is(bus_req.addr, wt_pkg::WMC_ADDR)) begin
            wmc_q <= bus_req.wdata & wt_pkg::WMC_RW_MASK;
        end else if (bus_req.bit_wr && addr_is(bus_req.addr, wt_pkg::WMC_ADDR)) begin
            wmc_q <= (wmc_q & ~(8'h01 << bus_req.bit_idx)
                      | ({7'h00, bus_req.wdata[0]} << bus_req.bit_idx))
                     & wt_pkg::WMC_RW_MASK;
        end
    end

    // Registered read data
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= wt_pkg::RD_UNMAPPED;
        end else if (bus_req.rd) begin
            if (addr_is(bus_req.addr, wt_pkg::TCS_ADDR)) begin
                rdata_q <= tcs_q;
            end else if (addr_is(bus_req.addr, wt_pkg::WMC_ADDR)) begin
                rdata_q <= wmc_q;
            end else begin
                rdata_q <= wt_pkg::RD_UNMAPPED;
            end
        end
    end

    // Main system clock tick: oscillator or every second oscillator tick
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            half_q <= 1'b0;
        end else if (osc_tick) begin
            half_q <= ~half_q;
        end
    end

    assign fxx_tick = osc_tick & (main_clock_undivided | half_q);

    // Divide main clock by 128
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_q <= '0;
        end else if (fxx_tick) begin
            div_q <= div_q + 1'b1;
        end
    end

    assign fw_tick = tcs_q[wt_pkg::TCS_SRC_BIT] ? sub_rise
                   : (fxx_tick & (&div_q));

    assign pre_run = wmc_q[wt_pkg::WMC_PRE_RUN_BIT];
    assign cnt_run = wmc_q[wt_pkg::WMC_CNT_RUN_BIT];
    assign ivl_code = wmc_q[wt_pkg::WMC_IVL_LSB +: 3];

    // Prescaler, shared by watch and interval functions
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pre_q <= '0;
        end else if (!pre_run) begin
            pre_q <= '0;
        end else if (fw_tick) begin
            pre_q <= pre_q + 1'b1;
        end
    end

    assign cnt_step = fw_tick & pre_run & low_ones(pre_q, wt_pkg::PRE_W);

    // Five-bit counter fed by the prescaler carry
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (!cnt_run) begin
            cnt_q <= '0;
        end else if (cnt_step) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Watch event: fast feed, half period or full period
    always_comb begin
        if (wmc_q[wt_pkg::WMC_FAST_BIT]) begin
            watch_hit = cnt_run & fw_tick & pre_run
                      & low_ones(pre_q, wt_pkg::FAST_EXP);
        end else if (wmc_q[wt_pkg::WMC_PERIOD_BIT]) begin
            watch_hit = cnt_run & cnt_step & (&cnt_q[wt_pkg::CNT_W-2:0]);
        end else begin
            watch_hit = cnt_run & cnt_step & (&cnt_q);
        end
    end

    // Interval request; prohibited codes raise nothing
    always_comb begin
        if (ivl_code <= wt_pkg::IVL_MAX_CODE) begin
            ivl_hit = fw_tick & pre_run
                    & low_ones(pre_q, int'(ivl_code) + wt_pkg::IVL_MIN_EXP);
        end else begin
            ivl_hit = 1'b0;
        end
    end

    // Sticky watch flag; a set wins over a clear in the same cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (watch_hit) begin
            flag_q <= 1'b1;
        end else if (watch_irq_flag_clr) begin
            flag_q <= 1'b0;
        end
    end

    // One-cycle request pulses
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            watch_irq_q <= 1'b0;
            interval_irq_q <= 1'b0;
        end else begin
            watch_irq_q <= watch_hit;
            interval_irq_q <= ivl_hit;
        end
    end

    assign bus_rdata = rdata_q;
    assign watch_irq_flag = flag_q;
    assign watch_irq = watch_irq_q;
    assign interval_irq = interval_irq_q;
    assign standby_release = flag_q & ~watch_irq_mask;
    assign sel_out.wdog_clock_sel = tcs_q[wt_pkg::TCS_WDOG_LSB +: 3];
    assign sel_out.buzzer_enable_bit = tcs_q[wt_pkg::TCS_BUZ_EN_BIT];
    assign sel_out.buzzer_freq_sel = tcs_q[wt_pkg::TCS_BUZ_LSB +: 2];
endmodule

// File: test/wt_checker.sv
`timescale 1ns/1ns
module wt_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wt_pkg::wt_bus_req_t bus_req,
    input wire logic [7:0] bus_rdata,
    input wire logic watch_irq_flag_clr,
    input wire logic watch_irq_mask,
    input wire logic watch_irq_flag,
    input wire logic watch_irq,
    input wire logic interval_irq,
    input wire logic standby_release,
    input wt_pkg::wt_sel_t sel_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    AST_REL: assert property (standby_release == (watch_irq_flag & ~watch_irq_mask))
        else $error("standby release wrong");
    AST_FLAG_CAUSE: assert property ($rose(watch_irq_flag) |-> watch_irq)
        else $error("flag rose alone");
    AST_FLAG_UP: assert property (watch_irq |-> watch_irq_flag)
        else $error("flag not set");
    AST_CLR: assert property (watch_irq_flag_clr |=> !watch_irq_flag || watch_irq)
        else $error("flag not cleared");
    AST_WPULSE: assert property (watch_irq |=> !watch_irq)
        else $error("watch pulse too long");
    AST_IPULSE: assert property (interval_irq |=> !interval_irq)
        else $error("interval pulse too long");
    AST_SEL: assert property (bus_req.wr && bus_req.addr == 16'hff42 |=>
        sel_out == {$past(bus_req.wdata[2:0]), $past(bus_req.wdata[7:5])})
        else $error("select fields wrong");
    AST_BIT: assert property (bus_req.bit_wr && !bus_req.wr && bus_req.addr == 16'hff42
        |=> $stable(sel_out))
        else $error("bit write changed select");
    AST_RD: assert property (bus_req.rd && bus_req.addr == 16'hff4a |=> !bus_rdata[7])
        else $error("mode bit7 set");
endmodule
bind wt_watch_timer wt_checker chk (.ref_clk, .rst, .bus_req, .bus_rdata, .watch_irq_flag_clr,
    .watch_irq_mask, .watch_irq_flag, .watch_irq, .interval_irq, .standby_release, .sel_out);

// File: test/wt_watch_timer_tb.sv
`timescale 1ns/1ns
module wt_watch_timer_tb;
    logic ref_clk = 1'b0, rst = 1'b1, osc_tick = 1'b0, main_clock_undivided = 1'b1;
    logic sub_clk_pin = 1'b0, watch_irq_flag_clr = 1'b0, watch_irq_mask = 1'b1;
    logic watch_irq_flag, watch_irq, interval_irq, standby_release;
    logic [7:0] bus_rdata, d;
    logic [15:0] lfsr_q = 16'h66a2;
    wt_pkg::wt_bus_req_t bus_req = '0;
    wt_pkg::wt_sel_t sel_out;
    int err_total = 0, compares = 0, n_ivl = 0, n_wt = 0, b;
    wt_watch_timer dut (.ref_clk, .rst, .bus_req, .bus_rdata, .osc_tick, .main_clock_undivided,
        .sub_clk_pin, .watch_irq_flag_clr, .watch_irq_mask, .watch_irq_flag, .watch_irq,
        .interval_irq, .standby_release, .sel_out);
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        n_ivl <= n_ivl + (interval_irq === 1'b1);
        n_wt <= n_wt + (watch_irq === 1'b1);
    end
    task automatic chk(logic [7:0] seen, logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] lfsr_next(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Clock select reads back with bit 3 as zero
    function automatic logic [7:0] exp_tcs(logic [7:0] v);
        return v & 8'hf7;
    endfunction
    // Exported selects: watchdog bits 2:0, then buzzer bits 7:5
    function automatic logic [7:0] exp_sel(logic [7:0] v);
        return {2'h0, v[2:0], v[7:5]};
    endfunction
    // Bit write: index in d[7:5], value in d[0]
    task automatic put(logic [15:0] a, logic [7:0] d, logic [2:0] k);
        bus_req = '{a, d, k[2], k[1], d[7:5], k[0]};
        @(negedge ref_clk);
        bus_req = '0;
        @(negedge ref_clk);
    endtask
    task automatic wm(logic [7:0] d);
        put(16'hff4a, d, 3'h4);
    endtask
    task automatic rd(logic [15:0] a, logic [7:0] e);
        put(a, 8'h00, 3'h1);
        chk(bus_rdata, e);
    endtask
    task automatic edges(int n);
        repeat (n) begin
            sub_clk_pin = 1'b1;
            @(negedge ref_clk);
            sub_clk_pin = 1'b0;
            @(negedge ref_clk);
        end
        repeat (4) @(negedge ref_clk);
    endtask
    task automatic stop_test;
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #360000;
        err_total++;
        stop_test();
    end
    initial begin
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        rd(16'hff42, 8'h00);
        rd(16'hff4a, 8'h00);
        rd(16'h1234, 8'h00);
        for (int i = 0; i < 8; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            d = {i[2:0], lfsr_q[4:0]};
            put(16'hff42, d, 3'h4);
            put(16'hff42, lfsr_q[15:8], 3'h2);
            rd(16'hff42, exp_tcs(d));
            chk(8'(sel_out), exp_sel(d));
        end
        wm(8'hff);
        rd(16'hff4a, 8'h7f);
        put(16'hff4a, 8'h20, 3'h2);
        rd(16'hff4a, 8'h7d);
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        rd(16'hff42, 8'h00);
        rd(16'hff4a, 8'h00);
        $display("registers done");
        wm(8'h00);
        put(16'hff42, 8'h10, 3'h4);
        for (int c = 0; c < 6; c++) begin
            wm({1'b0, c[2:0], 4'h6});
            edges(8);
            wm(8'h04);
            wm({1'b0, c[2:0], 4'h6});
            b = n_ivl;
            edges((16 << c) - 1);
            chk(8'(n_ivl - b), 8'h00);
            edges(1);
            chk(8'(n_ivl - b), 8'h01);
        end
        edges(512);
        chk(8'(n_ivl - b), 8'h02);
        wm(8'h66);
        b = n_ivl;
        edges(64);
        chk(8'(n_ivl - b), 8'h00);
        $display("interval done");
        wm(8'h00);
        wm(8'h07);
        b = n_wt;
        edges(31);
        chk(8'(n_wt - b), 8'h00);
        edges(1);
        chk(8'(n_wt - b), 8'h01);
        chk(8'(watch_irq_flag), 8'h01);
        watch_irq_mask = 1'b0;
        @(negedge ref_clk);
        chk(8'(standby_release), 8'h01);
        watch_irq_flag_clr = 1'b1;
        @(negedge ref_clk);
        watch_irq_flag_clr = 1'b0;
        chk(8'(watch_irq_flag), 8'h00);
        wm(8'h00);
        wm(8'h0e);
        edges(100);
        wm(8'h0a);
        wm(8'h0e);
        b = n_wt;
        edges(7680);
        chk(8'(n_wt - b), 8'h00);
        edges(512);
        chk(8'(n_wt - b), 8'h01);
        wm(8'h00);
        wm(8'h06);
        b = n_wt;
        edges(16383);
        chk(8'(n_wt - b), 8'h00);
        edges(1);
        chk(8'(n_wt - b), 8'h01);
        $display("subsystem clock done");
        wm(8'h00);
        put(16'hff42, 8'h00, 3'h4);
        osc_tick = 1'b1;
        for (int m = 1; m >= 0; m--) begin
            main_clock_undivided = m[0];
            wm(8'h00);
            wm(8'h06);
            b = n_ivl;
            repeat ((3840 >> m) - 16) @(negedge ref_clk);
            chk(8'(n_ivl - b), 8'h00);
            repeat ((256 >> m) + 40) @(negedge ref_clk);
            chk(8'(n_ivl - b), 8'h01);
        end
        $display("main clock done");
        stop_test();
    end
endmodule
